// ==== verilog/ppef_pkg.sv ====
// Constants for the port power event flag block: register indices,
// field positions, masks and reset values.
// Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
package ppef_pkg;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_VBUS_CHANGE_FLAGS      = 12'h809;
  localparam logic [11:0] IDX_POWER_EVENT_STATUS     = 12'h80a;
  localparam logic [11:0] IDX_DEBUG_EVENT_STATUS     = 12'h80b;
  localparam logic [11:0] IDX_CC_INTERRUPT_ENABLE    = 12'h811;
  localparam logic [11:0] IDX_CC1_MATCH_ENABLE       = 12'h812;
  localparam logic [11:0] IDX_CC2_MATCH_ENABLE       = 12'h813;
  localparam logic [11:0] IDX_VBUS_THRESHOLD_HITS_ENABLE      = 12'h814;
  localparam logic [11:0] IDX_POWER_INTERRUPT_ENABLE = 12'h815;

  // Power event status bit positions
  localparam int PWR_BIT_COMPARE_VALID  = 7;
  localparam int PWR_BIT_DRAIN_FAULT    = 6;
  localparam int PWR_BIT_CC2_BACKDRIVE  = 5;
  localparam int PWR_BIT_BUS_POWER_DRAINING_ERR = 4;
  localparam int PWR_BIT_SUPPLY2_ON     = 3;
  localparam int PWR_BIT_SUPPLY1_ON     = 2;
  localparam int PWR_BIT_CC1_BACKDRIVE  = 1;
  localparam int PWR_BIT_OVER_CURRENT   = 0;

  // Debug event status bit positions
  localparam int DBG_BIT_CABLE_DRAINING = 3;
  localparam int DBG_BIT_BUS_DRAINING   = 2;
  localparam int DBG_BIT_CFG1_DONE      = 1;
  localparam int DBG_BIT_CFG0_DONE      = 0;

  // CC interrupt enable fields
  localparam int CC_EN_BIT_PIN1 = 0;
  localparam int CC_EN_BIT_PIN2 = 1;
  localparam int CC_EN_AUX_LSB  = 4;

  // Writable and implemented bit masks
  localparam logic [7:0] VBUS_HIT_MASK      = 8'h3d;
  localparam logic [7:0] VBUS_THRESHOLD_HITS_ENABLE_MASK = 8'h3d;
  localparam logic [7:0] CC_INTERRUPT_ENABLE_MASK     = 8'hf3;
  localparam logic [7:0] DBG_STATUS_MASK    = 8'h0f;
  localparam logic [7:0] PWR_DFP_ONLY_MASK  = 8'h40;
  localparam logic [7:0] DBG_DFP_ONLY_MASK  = 8'h08;

  // Reset values
  localparam logic [7:0] FLAGS_RESET  = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;

  // Drain control codes that arm the cable-supply fault check
  localparam logic [1:0] DRAIN_CTRL_MODE0 = 2'h0;
  localparam logic [1:0] DRAIN_CTRL_MODE1 = 2'h1;

  // AXI responses
  localparam logic [1:0] AXI_RESP_OKAY   = 2'h0;
  localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PPEF_WR_IDLE = 2'b01,
    PPEF_WR_RESP = 2'b10
  } ppef_wr_state_type;

endpackage

// ==== verilog/ppef_flag_bank.sv ====
// Bank of sticky write-one-to-clear flags.
// Assumes set and clear are single-clock pulses or levels from this domain.
`timescale 1ns/10ps
module ppef_flag_bank #(
  parameter int         WIDTH      = 8,
  parameter logic [7:0] RESET_BITS = 8'h00
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] set_bits,
  input  wire logic [WIDTH-1:0] clear_bits,
  output logic      [WIDTH-1:0] flags
);

  if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
    $error("ppef_flag_bank: WIDTH must be 1 to 8");
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_flag
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          flags[g] <= RESET_BITS[g];
        end else if (set_bits[g]) begin
          flags[g] <= 1'b1;
        end else if (clear_bits[g]) begin
          flags[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// ==== verilog/ppef_vbus_watch.sv ====
// Watches the debounced VBUS threshold hits for per-bit changes and
// flags the first valid compare after the debouncer is enabled.
// Assumes all inputs come from logic on the same clock.
`timescale 1ns/10ps
module ppef_vbus_watch (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] vbus_threshold_hits,
  input  wire logic       vbus_debounce_enable,
  input  wire logic       vbus_compare_valid,
  output logic      [7:0] hit_change,
  output logic            first_valid
);

  logic [7:0] hits_prev_reg;
  logic       valid_seen_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hits_prev_reg <= 8'h00;
    end else begin
      hits_prev_reg <= vbus_threshold_hits;
    end
  end

  assign hit_change = (vbus_threshold_hits ^ hits_prev_reg)
                      & ppef_pkg::VBUS_HIT_MASK;

  // Re-arms whenever the debouncer is switched off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      valid_seen_reg <= 1'b0;
    end else if (!vbus_debounce_enable) begin
      valid_seen_reg <= 1'b0;
    end else if (vbus_compare_valid) begin
      valid_seen_reg <= 1'b1;
    end
  end

  assign first_valid = vbus_debounce_enable && vbus_compare_valid
                       && !valid_seen_reg;

endmodule

// ==== verilog/ppef_port_power_event_flags.sv ====
// Contract
// - VBUS change flag set on hit toggle
// - Write one clears flag, zero keeps
// - Bit 7 on first valid VBUS compare
// - Drain fault when control 00/01 times out
// - Drain fault bit only in standalone DFP
// - Back-drive levels set bits 5 and 1
// - VBUS discharge timeout pulse sets bit 4
// - Supply switch levels set bits 3, 2
// - Over-current level sets bit 0
// - Debug bit 3 cable draining, DFP only
// - Debug bit 2 while VBUS draining
// - Config pin done pulses set bits 0, 1
// - CC enables 7:4, 1:0; 3:2 reserved
// - CC match enables gate change flags
// - Vbus_threshold_hits enables; bit 1 RO, 7:6 reserved
// - Power enables gate each status bit
// - CC1 source reflects CC1 change flags
//
// Port power event flags with AXI4-Lite register access.
// Assumes event and level inputs come from logic on aclk.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/10ps
module ppef_port_power_event_flags #(
  parameter int ADDR_WIDTH = 16
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite slave
  input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic      [1:0]            s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic      [31:0]           s_axi_rdata,
  output logic      [1:0]            s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Mode and event sources
  input  wire logic                  standalone_dfp_mode,
  input  wire logic [7:0]            vbus_threshold_hits,
  input  wire logic                  vbus_debounce_enable,
  input  wire logic                  vbus_compare_valid,
  input  wire logic [1:0]            cable_supply_drain_ctrl,
  input  wire logic                  cable_supply_drain_timeout,
  input  wire logic                  cc2_backdrive,
  input  wire logic                  cc1_backdrive,
  input  wire logic                  bus_power_off_timeout,
  input  wire logic                  cable_supply2_on,
  input  wire logic                  cable_supply1_on,
  input  wire logic                  cable_supply_over_current,
  input  wire logic                  cable_supply_draining,
  input  wire logic                  bus_power_draining,
  input  wire logic                  config_pin_1_done,
  input  wire logic                  config_pin_0_done,
  input  wire logic [7:0]            cc1_change_flags,
  input  wire logic [7:0]            cc2_change_flags,
  input  wire logic [3:0]            cc_aux_events,
  // Interrupts and source levels
  output logic                       cc_pin1_change_event,
  output logic                       cc_pin2_change_event,
  output logic                       cc_interrupt,
  output logic                       bus_power_interrupt,
  output logic                       power_interrupt
);

  if (ADDR_WIDTH < 14 || ADDR_WIDTH > 32) begin : g_bad_width
    $error("ppef: ADDR_WIDTH must be 14 to 32");
  end

  // Bus state
  ppef_pkg::ppef_wr_state_type wr_state_reg;
  logic [ADDR_WIDTH-1:0] awaddr_reg;
  logic                  aw_held_reg;
  logic [7:0]            wdata_reg;
  logic                  wlane_reg;
  logic                  w_held_reg;
  logic                  wr_fire;
  logic                  wr_hit;
  logic                  rd_hit;
  logic [7:0]            rd_byte;
  logic [11:0]           wr_idx;
  logic [11:0]           rd_idx;
  logic                  wr_ok;
  logic                  rd_ok;

  // Registers
  logic [7:0] cc_interrupt_enable_reg;
  logic [7:0] cc1_match_enable_reg;
  logic [7:0] cc2_match_enable_reg;
  logic [7:0] vbus_threshold_hits_enable_reg;
  logic [7:0] power_interrupt_enable_reg;
  logic [7:0] vbus_change_flags;
  logic [7:0] power_event_status;
  logic [7:0] debug_event_status;

  // Event plumbing
  logic [7:0] vbus_change_set;
  logic       compare_first_valid;
  logic [7:0] pwr_set;
  logic [7:0] dbg_set;
  logic [7:0] vbus_clear;
  logic [7:0] pwr_clear;
  logic [7:0] dbg_clear;
  logic [7:0] pwr_visible;
  logic [7:0] dbg_visible;
  logic       drain_armed;

  // Address decode helpers
  assign wr_idx = awaddr_reg[13:2];
  assign rd_idx = s_axi_araddr[13:2];
  assign wr_ok  = (awaddr_reg[1:0] == 2'h0)
                  && ((awaddr_reg >> 14) == '0);
  assign rd_ok  = (s_axi_araddr[1:0] == 2'h0)
                  && ((s_axi_araddr >> 14) == '0);

  // Write channel: address and data taken in either order
  assign wr_fire = (wr_state_reg == ppef_pkg::PPEF_WR_IDLE)
                   && aw_held_reg && w_held_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      awaddr_reg    <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg   <= 1'b1;
      awaddr_reg    <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_held_reg   <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_reg
                       && (wr_state_reg == ppef_pkg::PPEF_WR_IDLE);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg   <= 1'b0;
      wdata_reg    <= 8'h00;
      wlane_reg    <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg   <= 1'b1;
      wdata_reg    <= s_axi_wdata[7:0];
      wlane_reg    <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_held_reg   <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_reg
                      && (wr_state_reg == ppef_pkg::PPEF_WR_IDLE);
    end
  end

  always_comb begin
    wr_hit = 1'b0;
    if (wr_ok) begin
      if (wr_idx == ppef_pkg::IDX_VBUS_CHANGE_FLAGS) begin
        wr_hit = 1'b1;
      end else if (wr_idx == ppef_pkg::IDX_POWER_EVENT_STATUS) begin
        wr_hit = 1'b1;
      end else if (wr_idx == ppef_pkg::IDX_DEBUG_EVENT_STATUS) begin
        wr_hit = 1'b1;
      end else if (wr_idx >= ppef_pkg::IDX_CC_INTERRUPT_ENABLE
                   && wr_idx <= ppef_pkg::IDX_POWER_INTERRUPT_ENABLE) begin
        wr_hit = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= ppef_pkg::PPEF_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ppef_pkg::AXI_RESP_OKAY;
    end else begin
      case (wr_state_reg)
        ppef_pkg::PPEF_WR_IDLE: begin
          if (wr_fire) begin
            wr_state_reg <= ppef_pkg::PPEF_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? ppef_pkg::AXI_RESP_OKAY
                                   : ppef_pkg::AXI_RESP_SLVERR;
          end
        end
        ppef_pkg::PPEF_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_reg <= ppef_pkg::PPEF_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state_reg <= ppef_pkg::PPEF_WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Byte lane 0 carries every register; other lanes are ignored
  function automatic logic wr_sel(input logic [11:0] idx);
    wr_sel = wr_fire && wr_ok && wlane_reg && (wr_idx == idx);
  endfunction

  // Reserved CC enable bits stay zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cc_interrupt_enable_reg <= ppef_pkg::ENABLE_RESET;
    end else if (wr_sel(ppef_pkg::IDX_CC_INTERRUPT_ENABLE)) begin
      cc_interrupt_enable_reg <= wdata_reg & ppef_pkg::CC_INTERRUPT_ENABLE_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cc1_match_enable_reg <= ppef_pkg::ENABLE_RESET;
    end else if (wr_sel(ppef_pkg::IDX_CC1_MATCH_ENABLE)) begin
      cc1_match_enable_reg <= wdata_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cc2_match_enable_reg <= ppef_pkg::ENABLE_RESET;
    end else if (wr_sel(ppef_pkg::IDX_CC2_MATCH_ENABLE)) begin
      cc2_match_enable_reg <= wdata_reg;
    end
  end

  // Bit 1 and bits 7:6 not writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vbus_threshold_hits_enable_reg <= ppef_pkg::ENABLE_RESET;
    end else if (wr_sel(ppef_pkg::IDX_VBUS_THRESHOLD_HITS_ENABLE)) begin
      vbus_threshold_hits_enable_reg <= wdata_reg & ppef_pkg::VBUS_THRESHOLD_HITS_ENABLE_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_interrupt_enable_reg <= ppef_pkg::ENABLE_RESET;
    end else if (wr_sel(ppef_pkg::IDX_POWER_INTERRUPT_ENABLE)) begin
      power_interrupt_enable_reg <= wdata_reg;
    end
  end

  always_comb begin
    vbus_clear = wr_sel(ppef_pkg::IDX_VBUS_CHANGE_FLAGS) ? wdata_reg : 8'h00;
    pwr_clear  = wr_sel(ppef_pkg::IDX_POWER_EVENT_STATUS) ? wdata_reg : 8'h00;
    dbg_clear  = wr_sel(ppef_pkg::IDX_DEBUG_EVENT_STATUS) ? wdata_reg : 8'h00;
  end

  ppef_vbus_watch u_vbus_watch (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .vbus_threshold_hits  (vbus_threshold_hits),
    .vbus_debounce_enable (vbus_debounce_enable),
    .vbus_compare_valid   (vbus_compare_valid),
    .hit_change           (vbus_change_set),
    .first_valid          (compare_first_valid)
  );

  ppef_flag_bank #(
    .WIDTH      (8),
    .RESET_BITS (ppef_pkg::FLAGS_RESET)
  ) u_vbus_flags (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .set_bits   (vbus_change_set),
    .clear_bits (vbus_clear),
    .flags      (vbus_change_flags)
  );

  // Fault checked only for two codes
  assign drain_armed =
    (cable_supply_drain_ctrl == ppef_pkg::DRAIN_CTRL_MODE0)
    || (cable_supply_drain_ctrl == ppef_pkg::DRAIN_CTRL_MODE1);

  always_comb begin
    pwr_set = 8'h00;
    pwr_set[ppef_pkg::PWR_BIT_COMPARE_VALID] = compare_first_valid;
    // Drain fault only in standalone DFP
    pwr_set[ppef_pkg::PWR_BIT_DRAIN_FAULT] =
      standalone_dfp_mode && drain_armed && cable_supply_drain_timeout;
    pwr_set[ppef_pkg::PWR_BIT_CC2_BACKDRIVE] = cc2_backdrive;
    pwr_set[ppef_pkg::PWR_BIT_CC1_BACKDRIVE] = cc1_backdrive;
    pwr_set[ppef_pkg::PWR_BIT_BUS_POWER_DRAINING_ERR] = bus_power_off_timeout;
    pwr_set[ppef_pkg::PWR_BIT_SUPPLY2_ON] = cable_supply2_on;
    pwr_set[ppef_pkg::PWR_BIT_SUPPLY1_ON] = cable_supply1_on;
    pwr_set[ppef_pkg::PWR_BIT_OVER_CURRENT] = cable_supply_over_current;
  end

  always_comb begin
    dbg_set = 8'h00;
    dbg_set[ppef_pkg::DBG_BIT_CABLE_DRAINING] =
      standalone_dfp_mode && cable_supply_draining;
    dbg_set[ppef_pkg::DBG_BIT_BUS_DRAINING] = bus_power_draining;
    dbg_set[ppef_pkg::DBG_BIT_CFG1_DONE] = config_pin_1_done;
    dbg_set[ppef_pkg::DBG_BIT_CFG0_DONE] = config_pin_0_done;
  end

  ppef_flag_bank #(
    .WIDTH      (8),
    .RESET_BITS (ppef_pkg::FLAGS_RESET)
  ) u_power_flags (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .set_bits   (pwr_set),
    .clear_bits (pwr_clear),
    .flags      (power_event_status)
  );

  ppef_flag_bank #(
    .WIDTH      (8),
    .RESET_BITS (ppef_pkg::FLAGS_RESET)
  ) u_debug_flags (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .set_bits   (dbg_set & ppef_pkg::DBG_STATUS_MASK),
    .clear_bits (dbg_clear),
    .flags      (debug_event_status)
  );

  // Outside DFP mode the bit reads as reserved zero
  assign pwr_visible = standalone_dfp_mode ? power_event_status
                       : (power_event_status & ~ppef_pkg::PWR_DFP_ONLY_MASK);
  assign dbg_visible = standalone_dfp_mode ? debug_event_status
                       : (debug_event_status & ~ppef_pkg::DBG_DFP_ONLY_MASK);

  // Read channel
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b0;
    if (!rd_ok) begin
      rd_hit = 1'b0;
    end else if (rd_idx == ppef_pkg::IDX_VBUS_CHANGE_FLAGS) begin
      rd_byte = vbus_change_flags;
      rd_hit  = 1'b1;
    end else if (rd_idx == ppef_pkg::IDX_POWER_EVENT_STATUS) begin
      rd_byte = pwr_visible;
      rd_hit  = 1'b1;
    end else if (rd_idx == ppef_pkg::IDX_DEBUG_EVENT_STATUS) begin
      rd_byte = dbg_visible;
      rd_hit  = 1'b1;
    end else if (rd_idx == ppef_pkg::IDX_CC_INTERRUPT_ENABLE) begin
      rd_byte = cc_interrupt_enable_reg;
      rd_hit  = 1'b1;
    end else if (rd_idx == ppef_pkg::IDX_CC1_MATCH_ENABLE) begin
      rd_byte = cc1_match_enable_reg;
      rd_hit  = 1'b1;
    end else if (rd_idx == ppef_pkg::IDX_CC2_MATCH_ENABLE) begin
      rd_byte = cc2_match_enable_reg;
      rd_hit  = 1'b1;
    end else if (rd_idx == ppef_pkg::IDX_VBUS_THRESHOLD_HITS_ENABLE) begin
      rd_byte = vbus_threshold_hits_enable_reg;
      rd_hit  = 1'b1;
    end else if (rd_idx == ppef_pkg::IDX_POWER_INTERRUPT_ENABLE) begin
      rd_byte = power_interrupt_enable_reg;
      rd_hit  = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ppef_pkg::AXI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_byte};
      s_axi_rresp   <= rd_hit ? ppef_pkg::AXI_RESP_OKAY
                              : ppef_pkg::AXI_RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Interrupt levels, registered so outputs come from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cc_pin1_change_event <= 1'b0;
      cc_pin2_change_event <= 1'b0;
    end else begin
      cc_pin1_change_event <= |(cc1_change_flags & cc1_match_enable_reg);
      cc_pin2_change_event <= |(cc2_change_flags & cc2_match_enable_reg);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cc_interrupt        <= 1'b0;
      bus_power_interrupt <= 1'b0;
      power_interrupt     <= 1'b0;
    end else begin
      cc_interrupt <=
        (cc_pin1_change_event
         && cc_interrupt_enable_reg[ppef_pkg::CC_EN_BIT_PIN1])
        || (cc_pin2_change_event
            && cc_interrupt_enable_reg[ppef_pkg::CC_EN_BIT_PIN2])
        || |(cc_aux_events
             & cc_interrupt_enable_reg[ppef_pkg::CC_EN_AUX_LSB +: 4]);
      bus_power_interrupt <= |(vbus_change_flags & vbus_threshold_hits_enable_reg);
      power_interrupt <= |(pwr_visible & power_interrupt_enable_reg);
    end
  end

endmodule

// ==== tb/ppef_properties.sv ====
// Checker for the port power event flag block: bus handshakes, CC source.
// Assumes it is bound into the top module and sees only its ports.
`timescale 1ns/10ps
module ppef_properties (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [7:0] cc1_change_flags,
  input wire logic       cc_pin1_change_event
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answered;
    ##2 s_axi_bvalid;
  endsequence
  AST_WR_ANSWER: assert property (wr_taken |-> wr_answered)
    else $error("write response not on time");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not on time");
  AST_AW_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel open during response");
  AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open during data");
  AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  AST_AR_BACK: assert property ($fell(s_axi_rvalid) |=> s_axi_arready)
    else $error("read address not reopened");
  // Two quiet samples cover either output latency
  AST_CC1_QUIET: assert property ($past(cc1_change_flags) == 8'h00 && $past(cc1_change_flags, 2) == 8'h00 |-> !cc_pin1_change_event)
    else $error("pin 1 source without change flags");
endmodule
bind ppef_port_power_event_flags ppef_properties u_ppef_properties (.*);

// ==== tb/test_port_power_event_flags.sv ====
// Bench for the port power event flag block: AXI4-Lite tasks, event
// stimulus, queued read checks. Assumes the checker is compiled first.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module test_port_power_event_flags;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0;
  logic [3:0]  s_axi_wstrb = 4'h1, cc_aux_events = '0;
  logic [1:0]  cable_supply_drain_ctrl = '0;
  logic [7:0]  vbus_threshold_hits = '0, cc1_change_flags = '0;
  logic [7:0]  cc2_change_flags = '0, h;
  logic        standalone_dfp_mode = 0, vbus_debounce_enable = 0;
  logic        vbus_compare_valid = 0, cable_supply_drain_timeout = 0;
  logic        cc2_backdrive = 0, cc1_backdrive = 0, bus_power_off_timeout = 0;
  logic        cable_supply2_on = 0, cable_supply1_on = 0;
  logic        cable_supply_over_current = 0, cable_supply_draining = 0;
  logic        bus_power_draining = 0, config_pin_1_done = 0;
  logic        config_pin_0_done = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, cc_pin1_change_event, cc_pin2_change_event;
  logic        cc_interrupt, bus_power_interrupt, power_interrupt;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [33:0] exq[$], want;
  logic [11:0] idx[8] = '{12'h809, 12'h80a, 12'h80b, 12'h811, 12'h812,
                          12'h813, 12'h814, 12'h815};
  logic [7:0]  msk[8] = '{8'h00, 8'h00, 8'h00, 8'hf3, 8'hff, 8'hff, 8'h3d,
                          8'hff};
  int          errors = 0, checked = 0;

  ppef_port_power_event_flags u_ppef_port_power_event_flags (.*);

  initial forever #2.5 aclk = ~aclk;

  task automatic give_verdict;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 60) begin
      errors++;
      give_verdict();
    end
  endtask

  // Sampling at the falling edge avoids racing the slave's own updates
  task automatic wr(input logic [11:0] i, input logic [7:0] d,
                    input logic [1:0] e);
    int n;
    logic sa, sw, sb;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(negedge aclk);
      {sa, sw, sb} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
      if (sb)
        `CHK(s_axi_bresp, e)
      @(posedge aclk);
      if (sa)
        s_axi_awvalid <= 1'b0;
      if (sw)
        s_axi_wvalid <= 1'b0;
      n++;
    end while (!sb && n < 60);
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask

  task automatic rd(input logic [11:0] i, input logic [7:0] d,
                    input logic [1:0] e);
    int n;
    logic sa, sv;
    n = 0;
    exq.push_back({e, 24'h0, d});
    @(posedge aclk);
    s_axi_araddr <= {2'h0, i, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(negedge aclk);
      {sa, sv} = {s_axi_arready, s_axi_rvalid};
      @(posedge aclk);
      if (sa)
        s_axi_arvalid <= 1'b0;
      n++;
    end while (!sv && n < 60);
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask

  always @(negedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      want = exq.size() ? exq.pop_front() : '1;
      `CHK({s_axi_rresp, s_axi_rdata}, want)
    end
  end

  initial begin
    void'($urandom(94255));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      rd(idx[k], 8'h00, 2'h0);
      wr(idx[k], 8'hff, 2'h0);
      rd(idx[k], msk[k], 2'h0);
    end
    h = 8'($urandom) & 8'h3d | 8'h01;
    @(posedge aclk);
    vbus_threshold_hits <= h;
    rd(idx[0], h, 2'h0);
    @(negedge aclk);
    `CHK(bus_power_interrupt, 1'b1)
    wr(idx[0], 8'h00, 2'h0);
    rd(idx[0], h, 2'h0);
    wr(idx[0], h, 2'h0);
    rd(idx[0], 8'h00, 2'h0);
    @(negedge aclk);
    `CHK(bus_power_interrupt, 1'b0)
    @(posedge aclk);
    {cc1_backdrive, cable_supply1_on, bus_power_off_timeout} <= 3'h7;
    @(posedge aclk);
    bus_power_off_timeout <= 1'b0;
    rd(idx[1], 8'h16, 2'h0);
    @(negedge aclk);
    `CHK(power_interrupt, 1'b1)
    // Levels still high must re-set at once
    wr(idx[1], 8'hff, 2'h0);
    rd(idx[1], 8'h06, 2'h0);
    @(posedge aclk);
    {cc1_backdrive, cable_supply1_on} <= 2'h0;
    {cc2_backdrive, cable_supply2_on, cable_supply_over_current} <= 3'h7;
    rd(idx[1], 8'h2f, 2'h0);
    @(posedge aclk);
    {cc2_backdrive, cable_supply2_on, cable_supply_over_current} <= 3'h0;
    wr(idx[1], 8'hff, 2'h0);
    rd(idx[1], 8'h00, 2'h0);
    @(negedge aclk);
    `CHK(power_interrupt, 1'b0)
    wr(idx[7], 8'hbf, 2'h0);
    for (int m = 0; m < 2; m++)
      for (int c = 0; c < 4; c++) begin
        @(posedge aclk);
        standalone_dfp_mode <= m[0];
        cable_supply_drain_ctrl <= c[1:0];
        cable_supply_drain_timeout <= 1'b1;
        @(posedge aclk);
        cable_supply_drain_timeout <= 1'b0;
        rd(idx[1], (m && c < 2) ? 8'h40 : 8'h00, 2'h0);
        @(negedge aclk);
        `CHK(power_interrupt, 1'b0)
        wr(idx[1], 8'h40, 2'h0);
      end
    @(posedge aclk);
    {config_pin_0_done, config_pin_1_done} <= 2'h3;
    {bus_power_draining, cable_supply_draining} <= 2'h3;
    @(posedge aclk);
    {config_pin_0_done, config_pin_1_done} <= 2'h0;
    rd(idx[2], 8'h0f, 2'h0);
    @(posedge aclk);
    standalone_dfp_mode <= 1'b0;
    {bus_power_draining, cable_supply_draining} <= 2'h0;
    rd(idx[2], 8'h07, 2'h0);
    wr(idx[2], 8'hff, 2'h0);
    rd(idx[2], 8'h00, 2'h0);
    @(posedge aclk);
    {vbus_debounce_enable, vbus_compare_valid} <= 2'h3;
    rd(idx[1], 8'h80, 2'h0);
    wr(idx[1], 8'h80, 2'h0);
    rd(idx[1], 8'h00, 2'h0);
    @(posedge aclk);
    cc1_change_flags <= 8'($urandom) | 8'h01;
    cc2_change_flags <= 8'h80;
    repeat (3) @(negedge aclk);
    `CHK({cc_pin1_change_event, cc_pin2_change_event, cc_interrupt}, 3'h7)
    wr(idx[4], 8'h00, 2'h0);
    repeat (3) @(negedge aclk);
    `CHK({cc_pin1_change_event, cc_pin2_change_event}, 2'h1)
    wr(idx[3], 8'h10, 2'h0);
    cc_aux_events <= 4'h1;
    repeat (3) @(negedge aclk);
    `CHK(cc_interrupt, 1'b1)
    wr(idx[3], 8'h0c, 2'h0);
    rd(idx[3], 8'h00, 2'h0);
    @(negedge aclk);
    `CHK(cc_interrupt, 1'b0)
    wr(12'h810, 8'hff, 2'h2);
    rd(12'h810, 8'h00, 2'h2);
    give_verdict();
  end
endmodule
